// >>> src/pbc_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Claim decoded cycles by asserting device select
// - Initiator aborts when no target claims in time
// - Initiator drives frame from start through transfers
// - Frame deasserted marks the final data phase
// - Accept grant without request, parking the bus
// - Configuration access answered only with select asserted
// - Initiator drives irdy, target drives trdy
// - Phase completes when irdy and trdy asserted
// - Any other edge is a wait state
// - Parity error driven only when enable bit 6
// - Request asserted while initiator work is pending
// - System error pulsed when enable bit 8
// - Card address parity error also pulses error
// - Target stop forces initiator to terminate
// - Even parity, driven one clock later, checked
module pbc_ctrl import pbc_pkg::*; #(
  parameter int MA_CLKS = PBC_MA_CLKS,
  parameter int FIFO_DEPTH = PBC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Address/data, command/byte enables, parity
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_n,
  input wire logic [3:0] cbe_n_i,
  output logic [3:0] cbe_n_o,
  output logic cbe_oe_n,
  input wire logic par_i,
  output logic par_o,
  output logic par_oe_n,
  // Shared control lines
  input wire logic frame_n_i,
  output logic frame_n_o,
  output logic frame_oe_n,
  input wire logic irdy_n_i,
  output logic irdy_n_o,
  output logic irdy_oe_n,
  input wire logic trdy_n_i,
  output logic trdy_n_o,
  output logic trdy_oe_n,
  input wire logic stop_n_i,
  output logic stop_n_o,
  output logic stop_oe_n,
  input wire logic devsel_n_i,
  output logic devsel_n_o,
  output logic devsel_oe_n,
  input wire logic perr_n_i,
  output logic perr_n_o,
  output logic perr_oe_n,
  // Arbitration, selection, system error
  input wire logic idsel,
  input wire logic gnt_n,
  output logic req_n,
  output logic serr_n_o,
  output logic serr_oe_n,
  // Configuration
  input wire logic [15:0] cmd_reg,
  input wire logic [31:PBC_BAR_LSB] bar_base,
  input wire logic tgt_single,
  // Initiator requests and write data
  input wire logic ini_start,
  input wire pbc_ireq_t ini_req,
  output logic ini_busy,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_data,
  output logic ini_done,
  output logic ini_abort,
  output logic ini_stopped,
  // Target write data
  output logic tgt_valid,
  output pbc_tdat_t tgt_dat,
  // Error events
  input wire logic sys_err,
  input wire logic card_aperr,
  output logic perr_seen
);

  typedef enum {I_IDLE, I_DATA, I_TURN} pbc_ist_t;
  typedef enum {T_IDLE, T_DATA, T_TURN} pbc_tst_t;

  pbc_ist_t ist_q;
  pbc_tst_t tst_q;
  pbc_ireq_t ireq_q;
  logic pend_q;
  logic claim_q;
  logic abort_q;
  logic [3:0] ma_cnt_q;
  logic [3:0] left_q;
  logic frame_prev_q;
  logic [31:0] taddr_q;
  logic tcfg_q;
  logic pcalc_q;
  logic dchk_q;
  logic achk_q;
  logic fifo_valid;
  logic [31:0] fifo_data;

  // Target decode: memory window writes, or configuration writes with select
  function automatic logic t_hit(input logic [3:0] c, input logic [31:0] a,
                                 input logic sel);
    return (c == PBC_CMD_MEMWR && a[31:PBC_BAR_LSB] == bar_base) ||
           (c == PBC_CMD_CFGWR && sel && a[1:0] == 2'b00);
  endfunction : t_hit

  logic xfer;
  logic ph_end;
  logic bus_idle;
  logic go;
  logic park;
  logic ma_hit;
  logic ld;
  logic addr_ph;
  logic t_end;
  logic dbad;
  logic abad;

  assign xfer = !irdy_n_i && !trdy_n_i;
  assign ph_end = !irdy_n_i && (!trdy_n_i || !stop_n_i);
  assign bus_idle = frame_n_i && irdy_n_i;
  assign go = ist_q == I_IDLE && pend_q && !gnt_n && bus_idle;
  assign park = ist_q == I_IDLE && !pend_q && !gnt_n && bus_idle;
  assign ma_hit = ist_q == I_DATA && !claim_q && !abort_q && devsel_n_i &&
                  ma_cnt_q == 4'(MA_CLKS - 1);
  assign ld = ist_q == I_DATA && irdy_n_o && !frame_n_o && fifo_valid &&
              stop_n_i && !ma_hit;
  // Own address phases are excluded so the block never targets itself
  assign addr_ph = !frame_n_i && frame_prev_q && ist_q == I_IDLE;
  assign t_end = tst_q == T_DATA && frame_n_i && ph_end;
  assign dbad = dchk_q && (par_i != pcalc_q);
  assign abad = achk_q && (par_i != pcalc_q);

  // Write data waits here so software can queue a burst ahead of the grant
  pbc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(ld),
    .out_data(fifo_data)
  );

  // Request bookkeeping
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      ini_busy <= 1'b0;
      req_n <= 1'b1;
      ireq_q <= '0;
    end else begin
      if (ini_start && !ini_busy) begin
        pend_q <= 1'b1;
        ini_busy <= 1'b1;
        req_n <= 1'b0;
        ireq_q <= ini_req;
      end else if (go) begin
        pend_q <= 1'b0;
        req_n <= 1'b1;
      end
      if (ist_q == I_TURN) begin
        ini_busy <= 1'b0;
      end
    end
  end

  // Initiator pin drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      ist_q <= I_IDLE;
      frame_n_o <= 1'b1;
      frame_oe_n <= 1'b1;
      irdy_n_o <= 1'b1;
      irdy_oe_n <= 1'b1;
      ad_o <= '0;
      ad_oe_n <= 1'b1;
      cbe_n_o <= '0;
      cbe_oe_n <= 1'b1;
      left_q <= '0;
    end else begin
      unique case (ist_q)
        I_IDLE: begin
          ad_oe_n <= !park;
          cbe_oe_n <= !park;
          if (go) begin
            ist_q <= I_DATA;
            frame_n_o <= 1'b0;
            frame_oe_n <= 1'b0;
            irdy_n_o <= 1'b1;
            irdy_oe_n <= 1'b0;
            ad_o <= ireq_q.addr;
            cbe_n_o <= ireq_q.cmd;
            ad_oe_n <= 1'b0;
            cbe_oe_n <= 1'b0;
            left_q <= ireq_q.words;
          end
        end
        I_DATA: begin
          cbe_n_o <= PBC_BE_ALL_N;
          if (ma_hit) begin
            frame_n_o <= 1'b1;
            irdy_n_o <= 1'b0;
          end else if (!irdy_n_o && (ph_end || abort_q)) begin
            irdy_n_o <= 1'b1;
            if (frame_n_o) begin
              ist_q <= I_TURN;
            end
          end else if (ld) begin
            ad_o <= fifo_data;
            irdy_n_o <= 1'b0;
            frame_n_o <= left_q == 4'h1;
          end else if (!stop_n_i && irdy_n_o) begin
            irdy_n_o <= 1'b0;
          end
          if (!stop_n_i && !frame_n_o) begin
            frame_n_o <= 1'b1;
          end
          if (xfer && !irdy_n_o) begin
            left_q <= left_q - 4'h1;
          end
        end
        I_TURN: begin
          // Lines were driven high last cycle; now release them
          ist_q <= I_IDLE;
          frame_oe_n <= 1'b1;
          irdy_oe_n <= 1'b1;
          ad_oe_n <= 1'b1;
          cbe_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Claim watch and initiator events
  always_ff @(posedge clk) begin
    if (rst) begin
      claim_q <= 1'b0;
      abort_q <= 1'b0;
      ma_cnt_q <= '0;
      ini_done <= 1'b0;
      ini_abort <= 1'b0;
      ini_stopped <= 1'b0;
    end else begin
      ini_done <= ist_q == I_DATA && !irdy_n_o && frame_n_o &&
                  (ph_end || abort_q);
      ini_abort <= ma_hit;
      ini_stopped <= ist_q == I_DATA && !stop_n_i && !frame_n_o;
      if (ist_q != I_DATA) begin
        claim_q <= 1'b0;
        abort_q <= 1'b0;
        ma_cnt_q <= '0;
      end else begin
        if (!devsel_n_i) begin
          claim_q <= 1'b1;
        end
        if (ma_hit) begin
          abort_q <= 1'b1;
        end
        if (!claim_q && devsel_n_i && !abort_q) begin
          ma_cnt_q <= ma_cnt_q + 4'h1;
        end
      end
    end
  end

  // Target pin drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      tst_q <= T_IDLE;
      frame_prev_q <= 1'b1;
      devsel_n_o <= 1'b1;
      devsel_oe_n <= 1'b1;
      trdy_n_o <= 1'b1;
      trdy_oe_n <= 1'b1;
      stop_n_o <= 1'b1;
      stop_oe_n <= 1'b1;
      taddr_q <= '0;
      tcfg_q <= 1'b0;
    end else begin
      frame_prev_q <= frame_n_i;
      unique case (tst_q)
        T_IDLE: begin
          if (addr_ph && t_hit(cbe_n_i, ad_i, idsel)) begin
            tst_q <= T_DATA;
            devsel_n_o <= 1'b0;
            devsel_oe_n <= 1'b0;
            trdy_n_o <= 1'b0;
            trdy_oe_n <= 1'b0;
            // Single-word targets disconnect with the first data
            stop_n_o <= !tgt_single;
            stop_oe_n <= 1'b0;
            taddr_q <= ad_i;
            tcfg_q <= cbe_n_i == PBC_CMD_CFGWR;
          end
        end
        T_DATA: begin
          if (t_end) begin
            tst_q <= T_TURN;
            devsel_n_o <= 1'b1;
            trdy_n_o <= 1'b1;
            stop_n_o <= 1'b1;
          end else if (xfer && !stop_n_o) begin
            trdy_n_o <= 1'b1;
          end
          if (xfer) begin
            taddr_q <= taddr_q + 32'h4;
          end
        end
        T_TURN: begin
          tst_q <= T_IDLE;
          devsel_oe_n <= 1'b1;
          trdy_oe_n <= 1'b1;
          stop_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Target data delivery
  always_ff @(posedge clk) begin
    if (rst) begin
      tgt_valid <= 1'b0;
      tgt_dat <= '0;
    end else begin
      tgt_valid <= tst_q == T_DATA && xfer;
      if (tst_q == T_DATA && xfer) begin
        tgt_dat <= '{addr: taddr_q, data: ad_i, be_n: cbe_n_i, cfg: tcfg_q};
      end
    end
  end

  // Parity generation and checking
  always_ff @(posedge clk) begin
    if (rst) begin
      par_o <= 1'b0;
      par_oe_n <= 1'b1;
      pcalc_q <= 1'b0;
      dchk_q <= 1'b0;
      achk_q <= 1'b0;
      perr_n_o <= 1'b1;
      perr_oe_n <= 1'b1;
      perr_seen <= 1'b0;
    end else begin
      par_o <= pbc_par(ad_o, cbe_n_o);
      par_oe_n <= ad_oe_n;
      pcalc_q <= pbc_par(ad_i, cbe_n_i);
      dchk_q <= tst_q == T_DATA && xfer;
      achk_q <= addr_ph;
      perr_seen <= dbad;
      if (dbad && cmd_reg[PBC_PERR_EN_BIT]) begin
        perr_n_o <= 1'b0;
        perr_oe_n <= 1'b0;
      end else if (!perr_n_o) begin
        // Drive the shared line high for one clock before releasing it
        perr_n_o <= 1'b1;
      end else begin
        perr_oe_n <= 1'b1;
      end
    end
  end

  // System error: one-clock low pulses; a held cause yields spaced pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      serr_n_o <= 1'b0;
      serr_oe_n <= 1'b1;
    end else begin
      serr_n_o <= 1'b0;
      serr_oe_n <= !(cmd_reg[PBC_SERR_EN_BIT] && serr_oe_n &&
                     (sys_err || card_aperr || abad));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_claim;
    tst_q == T_IDLE && addr_ph && t_hit(cbe_n_i, ad_i, idsel);
  endsequence
  sequence s_go;
    ist_q == I_IDLE && pend_q && !gnt_n && bus_idle;
  endsequence
  sequence s_last_done;
    ist_q == I_DATA && frame_n_o && !irdy_n_o && ph_end && !abort_q;
  endsequence

  devsel_claim_a: assert property (s_claim |=> !devsel_n_o && !devsel_oe_n ##1 !devsel_oe_n)
    else $error("decoded cycle not claimed");
  master_abort_a: assert property (ma_hit |=> ini_abort && frame_n_o && !irdy_n_o ##1 irdy_n_o)
    else $error("missing master abort");
  frame_start_a: assert property (s_go |=> !frame_n_o && !frame_oe_n && ist_q == I_DATA)
    else $error("frame not driven at start");
  frame_last_a: assert property (s_last_done |=> irdy_n_o && ist_q == I_TURN ##1 frame_oe_n)
    else $error("final phase not closed");
  park_drive_a: assert property (park |=> !ad_oe_n && !cbe_oe_n ##1 !par_oe_n)
    else $error("parked bus not driven");
  idsel_gate_a: assert property (tst_q == T_IDLE && addr_ph && cbe_n_i == PBC_CMD_CFGWR &&
                                 !idsel |=> devsel_oe_n)
    else $error("config claimed without select");
  wait_state_a: assert property (tst_q == T_DATA && !xfer |=> !tgt_valid)
    else $error("data taken in wait state");
  data_done_a: assert property (tst_q == T_DATA && xfer |=> tgt_valid && tgt_dat.data == $past(ad_i))
    else $error("completed phase not delivered");
  perr_gate_a: assert property ($fell(perr_n_o) |-> $past(cmd_reg[PBC_PERR_EN_BIT]) && $past(dbad))
    else $error("parity error driven while disabled");
  req_raise_a: assert property (ini_start && !ini_busy |=> !req_n && pend_q)
    else $error("request not raised");
  serr_pulse_a: assert property ($fell(serr_oe_n) |-> $past(cmd_reg[PBC_SERR_EN_BIT]) ##1 serr_oe_n)
    else $error("system error pulse malformed");
  stop_end_a: assert property (ist_q == I_DATA && !stop_n_i && !frame_n_o |=> frame_n_o)
    else $error("stop not honoured");
  par_delay_a: assert property (!ad_oe_n |=> !par_oe_n && par_o == pbc_par($past(ad_o), $past(cbe_n_o)))
    else $error("parity not driven one clock later");

endmodule : pbc_ctrl

// >>> pkg/pbc_pkg.sv
package pbc_pkg;

  // Configuration command register location and enable bits
  localparam logic [7:0] PBC_CMD_REG_OFS = 8'h04;
  localparam int PBC_PERR_EN_BIT = 6;
  localparam int PBC_SERR_EN_BIT = 8;

  // Clocks an initiator waits for a claim before a master abort
  localparam int PBC_MA_CLKS = 5;

  // Write data buffer depth
  localparam int PBC_FIFO_DEPTH = 4;

  // Lowest address bit compared against the memory window base
  localparam int PBC_BAR_LSB = 12;

  // Bus command codes; this block handles only the memory and configuration writes
  localparam logic [3:0] PBC_CMD_IOWR = 4'h3;
  localparam logic [3:0] PBC_CMD_MEMWR = 4'h7;
  localparam logic [3:0] PBC_CMD_CFGWR = 4'hb;

  // Byte enables driven in initiator data phases (active low, all bytes)
  localparam logic [3:0] PBC_BE_ALL_N = 4'h0;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] words;
  } pbc_ireq_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be_n;
    logic cfg;
  } pbc_tdat_t;

  // Even parity bit over address/data and command/byte-enable lines
  function automatic logic pbc_par(input logic [31:0] ad, input logic [3:0] cbe);
    return ^{ad, cbe};
  endfunction : pbc_par

endpackage : pbc_pkg

// >>> src/pbc_fifo.sv
`timescale 1ns/1ps
module pbc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : pbc_fifo

// >>> verif/pbc_agent.sv
`timescale 1ns/1ps
module pbc_agent (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Resolved lines
  input wire logic frame_l,
  input wire logic irdy_l,
  input wire logic trdy_l,
  input wire logic devsel_l,
  input wire logic [31:0] ad_l,
  // Target mode: 0 silent, 1 claim, 2 claim and stop
  input wire logic [1:0] t_mode,
  input wire logic [1:0] t_wait,
  // Target drive
  output logic t_oe,
  output logic t_devsel,
  output logic t_trdy,
  output logic t_stop,
  // Initiator drive
  output logic i_oe,
  output logic i_ad_oe,
  output logic i_par_oe,
  output logic i_frame,
  output logic i_irdy,
  output logic [31:0] i_ad,
  output logic [3:0] i_cbe,
  output logic i_par
);
  logic [31:0] got[$];
  logic frm[$];
  logic act, rel, frm_p;
  logic [1:0] cnt;

  initial begin
    i_oe = 0;
    i_ad_oe = 0;
    i_par_oe = 0;
    i_frame = 1;
    i_irdy = 1;
  end

  always @(posedge clk) begin
    frm_p <= frame_l;
    if (rst) begin
      act <= 0;
      rel <= 0;
      t_oe <= 0;
      t_devsel <= 1;
      t_trdy <= 1;
      t_stop <= 1;
    end else if (rel) begin
      rel <= 0;
      t_oe <= 0;
    end else if (!act) begin
      if (!frame_l && frm_p && !i_oe && t_mode != 2'h0) begin
        act <= 1;
        t_oe <= 1;
        t_devsel <= 0;
        t_trdy <= (t_wait != 2'h0);
        t_stop <= (t_mode != 2'h2);
        cnt <= 0;
      end
    end else begin
      if (!irdy_l && !t_trdy) begin
        got.push_back(ad_l);
        frm.push_back(frame_l);
      end
      // A frame-high, irdy-high cycle after a stop is not the last phase yet
      if (frame_l && !irdy_l && (!t_trdy || !t_stop)) begin
        act <= 0;
        rel <= 1;
        t_devsel <= 1;
        t_trdy <= 1;
        t_stop <= 1;
      end else if (!irdy_l && !t_trdy) begin
        cnt <= 0;
        t_trdy <= (t_wait != 2'h0) || !t_stop;
      end else if (t_trdy && t_stop) begin
        cnt <= cnt + 2'h1;
        t_trdy <= (cnt + 2'h1 < t_wait);
      end
    end
  end

  // Single-phase write; gives up after five clocks unclaimed
  task automatic ini_write(input logic [31:0] a, input logic [3:0] c, input logic [31:0] d,
                           input logic bad, output logic claimed);
    int k;
    claimed = 0;
    @(posedge clk);
    i_oe <= 1;
    i_ad_oe <= 1;
    i_frame <= 0;
    i_ad <= a;
    i_cbe <= c;
    @(posedge clk);
    i_frame <= 1;
    i_irdy <= 0;
    i_ad <= d;
    i_cbe <= 4'h0;
    i_par <= (^{a, c}) ^ bad;
    i_par_oe <= 1;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      i_par <= (^{d, 4'h0}) ^ bad;
      claimed |= !devsel_l;
      if (!trdy_l || (k == 4 && !claimed)) break;
    end
    i_irdy <= 1;
    i_ad_oe <= 0;
    @(posedge clk);
    i_oe <= 0;
    i_par_oe <= 0;
  endtask : ini_write
endmodule : pbc_agent

// >>> verif/pci_bus_control_signalling_tb_top.sv
`timescale 1ns/1ps
module pci_bus_control_signalling_tb_top import pbc_pkg::*;;
  logic clk = 0;
  logic rst, idsel, gnt_n, tgt_single, ini_start, wr_valid, sys_err, card_aperr;
  logic [15:0] cmd_reg;
  logic [31:PBC_BAR_LSB] bar_base;
  pbc_ireq_t ini_req;
  logic [31:0] wr_data, ad_o, i_ad, ad_l, ad_q;
  logic [3:0] cbe_n_o, i_cbe, cbe_l, cbe_q;
  logic ad_oe_n, cbe_oe_n, par_o, par_oe_n, frame_n_o, frame_oe_n, irdy_n_o, irdy_oe_n;
  logic trdy_n_o, trdy_oe_n, stop_n_o, stop_oe_n, devsel_n_o, devsel_oe_n, perr_n_o, perr_oe_n;
  logic req_n, serr_n_o, serr_oe_n, ini_busy, wr_ready, ini_done, ini_abort, ini_stopped;
  logic tgt_valid, perr_seen, par_l, par_q, aoe_q;
  pbc_tdat_t tgt_dat, td;
  pbc_tdat_t tq[$];
  logic [31:0] wq[$];
  logic t_oe, t_devsel, t_trdy, t_stop, i_oe, i_ad_oe, i_par_oe, i_frame, i_irdy, i_par;
  logic [1:0] t_mode, t_wait;
  logic frame_l, irdy_l, trdy_l, stop_l, devsel_l, perr_l;
  logic [31:0] seed = 32'h1b229f3b;
  int err_total, num_checks, cyc, n_serr, n_perr, n_ps, n_ab, n_st, k;
  logic [31:0] w;

  always #50 clk = ~clk;

  // Control lines are pulled up; AD and PAR float, shown as inverse of last value
  assign frame_l = (frame_oe_n | frame_n_o) & (!i_oe | i_frame);
  assign irdy_l = (irdy_oe_n | irdy_n_o) & (!i_oe | i_irdy);
  assign trdy_l = (trdy_oe_n | trdy_n_o) & (!t_oe | t_trdy);
  assign stop_l = (stop_oe_n | stop_n_o) & (!t_oe | t_stop);
  assign devsel_l = (devsel_oe_n | devsel_n_o) & (!t_oe | t_devsel);
  assign perr_l = perr_oe_n | perr_n_o;
  assign ad_l = !ad_oe_n ? ad_o : i_ad_oe ? i_ad : ~ad_q;
  assign cbe_l = !cbe_oe_n ? cbe_n_o : i_ad_oe ? i_cbe : ~cbe_q;
  assign par_l = !par_oe_n ? par_o : i_par_oe ? i_par : ~par_q;

  pbc_ctrl u_pbc_ctrl (.clk, .rst, .ad_i(ad_l), .ad_o, .ad_oe_n, .cbe_n_i(cbe_l), .cbe_n_o,
    .cbe_oe_n, .par_i(par_l), .par_o, .par_oe_n, .frame_n_i(frame_l), .frame_n_o, .frame_oe_n,
    .irdy_n_i(irdy_l), .irdy_n_o, .irdy_oe_n, .trdy_n_i(trdy_l), .trdy_n_o, .trdy_oe_n,
    .stop_n_i(stop_l), .stop_n_o, .stop_oe_n, .devsel_n_i(devsel_l), .devsel_n_o,
    .devsel_oe_n, .perr_n_i(perr_l), .perr_n_o, .perr_oe_n, .idsel, .gnt_n, .req_n,
    .serr_n_o, .serr_oe_n, .cmd_reg, .bar_base, .tgt_single, .ini_start, .ini_req,
    .ini_busy, .wr_valid, .wr_ready, .wr_data, .ini_done, .ini_abort, .ini_stopped,
    .tgt_valid, .tgt_dat, .sys_err, .card_aperr, .perr_seen);

  pbc_agent u_pbc_agent (.clk, .rst, .frame_l, .irdy_l, .trdy_l, .devsel_l, .ad_l, .t_mode,
    .t_wait, .t_oe, .t_devsel, .t_trdy, .t_stop, .i_oe, .i_ad_oe, .i_par_oe, .i_frame,
    .i_irdy, .i_ad, .i_cbe, .i_par);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic ep(input logic [31:0] a, input logic [3:0] c);
    return ^{a, c};
  endfunction : ep

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Zeroed off the edge so the monitor never races it
  task automatic clr();
    @(negedge clk);
    {n_serr, n_perr, n_ps, n_ab, n_st} = '0;
    @(posedge clk);
  endtask : clr

  always @(posedge clk) begin
    ad_q <= ad_l;
    cbe_q <= cbe_l;
    par_q <= par_l;
    aoe_q <= ad_oe_n;
    cyc++;
    if (!rst) begin
      if (!par_oe_n && !aoe_q) chk("par", ep(ad_q, cbe_q), par_l);
      if (!serr_oe_n) chk("serr level", 0, serr_n_o);
      n_serr += !serr_oe_n;
      n_perr += !perr_l;
      n_ps += perr_seen;
      n_ab += ini_abort;
      n_st += ini_stopped;
      if (tgt_valid) tq.push_back(tgt_dat);
    end
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic dev_write(input int np, input int nw, input logic [1:0] md,
                           input logic [1:0] wt, input logic hold);
    int j, e;
    for (j = 0; j < np; j++) begin
      w = rnd();
      wq.push_back(w);
      wr_valid <= 1;
      wr_data <= w;
      @(posedge clk);
      while (wr_ready !== 1'b1) @(posedge clk);
    end
    wr_valid <= 0;
    @(posedge clk);
    if (wq.size() == PBC_FIFO_DEPTH) chk("wr_ready full", 0, wr_ready);
    clr();
    w = rnd();
    t_mode <= md;
    t_wait <= wt;
    ini_req <= '{addr: {w[31:2], 2'b00}, cmd: PBC_CMD_MEMWR, words: 4'(nw)};
    ini_start <= 1;
    if (hold) gnt_n <= 1;
    @(posedge clk);
    ini_start <= 0;
    if (hold) begin
      repeat (4) @(posedge clk);
      chk("req_n", 0, req_n);
      chk("busy", 1, ini_busy);
      chk("frame held", 1, frame_l);
      gnt_n <= 0;
    end
    for (j = 0; j < 300 && ini_done !== 1'b1; j++) @(posedge clk);
    chk("done", 1, ini_done);
    repeat (3) @(posedge clk);
    chk("busy end", 0, ini_busy);
    e = (md == 2'h0) ? 0 : (md == 2'h2) ? 1 : nw;
    chk("abort", md == 2'h0, n_ab);
    chk("stopped", md == 2'h2, n_st);
    chk("phases", e, u_pbc_agent.got.size());
    for (j = 0; j < e; j++) begin
      chk("word", wq.pop_front(), u_pbc_agent.got[j]);
      if (md == 2'h1) chk("last", j == nw - 1, u_pbc_agent.frm[j]);
    end
    if (md == 2'h0) w = wq.pop_front();
    u_pbc_agent.got.delete();
    u_pbc_agent.frm.delete();
  endtask : dev_write

  task automatic tgt_case(input int i);
    logic [31:0] a, d;
    logic [3:0] c;
    logic b, cl, ex;
    d = rnd();
    a = {bar_base, 12'h000} | (rnd() & 32'h0000_0ffc);
    c = (i == 2 || i == 3) ? PBC_CMD_CFGWR : PBC_CMD_MEMWR;
    b = (i >= 4);
    ex = !(i == 1 || i == 3);
    if (i == 1) a[31] = ~a[31];
    idsel <= (i == 2);
    cmd_reg <= (i == 5) ? 16'h0100 : 16'h0140;
    tgt_single <= i[0];
    clr();
    u_pbc_agent.ini_write(a, c, d, b, cl);
    repeat (4) @(posedge clk);
    chk("claim", ex, cl);
    chk("tgt count", ex, tq.size());
    if (ex) begin
      td = tq.pop_front();
      chk("tgt addr", a, td.addr);
      chk("tgt data", d, td.data);
      chk("tgt cfg", c == PBC_CMD_CFGWR, td.cfg);
      chk("tgt be", 0, td.be_n);
    end
    chk("perr line", i == 4, n_perr);
    chk("perr seen", b && ex, n_ps);
    chk("serr addr par", b, n_serr);
    tq.delete();
  endtask : tgt_case

  initial begin
    rst = 1;
    {idsel, gnt_n, tgt_single, ini_start, wr_valid, sys_err, card_aperr} = 7'h20;
    cmd_reg = 16'h0140;
    bar_base = 20'hc3a50;
    ini_req = '0;
    wr_data = 0;
    t_mode = 1;
    t_wait = 0;
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    gnt_n <= 0;
    dev_write(4, 4, 2'h1, 2'h0, 0);
    dev_write(1, 1, 2'h1, 2'h1, 1);
    dev_write(2, 2, 2'h2, 2'h0, 0);
    dev_write(0, 1, 2'h1, 2'h0, 0);
    dev_write(1, 1, 2'h0, 2'h0, 0);
    for (k = 0; k < 6; k++) begin
      w = rnd();
      dev_write(w[1:0] + 1, w[1:0] + 1, 2'h1, w[3:2], 0);
    end
    gnt_n <= 1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 6; k++) tgt_case(k);
    for (k = 0; k < 4; k++) begin
      cmd_reg <= k[0] ? 16'h0140 : 16'h0040;
      clr();
      sys_err <= !k[1];
      card_aperr <= k[1];
      @(posedge clk);
      sys_err <= 0;
      card_aperr <= 0;
      repeat (5) @(posedge clk);
      chk("serr pulses", k[0], n_serr);
    end
    wrap_up();
  end
endmodule : pci_bus_control_signalling_tb_top
